//--- core/stm_top.v
`timescale 1ns/1ns
`default_nettype none
`include "stm_defs.vh"
module stm_top #(
  parameter [`STM_CNT_W-1:0] FILT_CYCLES = `STM_FILT_CYCLES
) (
  input wire CLK_SYS,
  input wire RST,
  input wire SAFE_IN_A_CLOSED,
  input wire SAFE_IN_B_CLOSED,
  input wire [`STM_AXES-1:0] AXIS_SPEED_NZ,
  input wire [`STM_AXES-1:0] AXIS_TORQUE_MODE,
  input wire FORCED_STOP_DECEL_IN_N,
  input wire ALARM_CLEAR,
  output reg SHUTOFF_MON_A_ON,
  output reg SHUTOFF_MON_B_ON,
  output reg SHUTOFF_MON_AB_ON,
  output reg [`STM_AXES-1:0] BASE_DRIVE_EN,
  output reg [`STM_AXES-1:0] DYN_BRAKE_ON,
  output reg [`STM_AXES-1:0] DECEL_ALLOWED,
  output reg SHUTOFF_TIMING_ALARM,
  output reg [7:0] ALARM_CODE
);
  // Filtered channel states, high while that channel is shut off
  wire cut_a;
  wire cut_b;
  // Either channel cut; one open input alone is enough to stop
  wire cut_any;
  // Both channels cut; only then does the combined monitor path conduct
  wire cut_both;
  // High for one cycle, the first cycle that the either-channel cut (cut_any) is high
  wire cut_rise;
  // Any axis moving, judged only after synchronisation
  wire speed_any;

  // Speed, clear and forced-stop inputs, two stages each before any logic reads them; AXIS_TORQUE_MODE is read directly
  reg [`STM_AXES-1:0] speed_s1_ff;
  reg [`STM_AXES-1:0] speed_s2_ff;
  reg clr_s1_ff;
  reg clr_s2_ff;
  reg em_s1_ff;
  reg em_s2_ff;

  // Edge detector and sticky timing alarm
  reg cut_any_d_ff;
  reg alarm_ff;
  reg nxt_alarm;

  // Next values of the registered outputs
  reg nxt_mon_a;
  reg nxt_mon_b;
  reg nxt_mon_ab;
  reg [`STM_AXES-1:0] nxt_base_drive;
  reg [`STM_AXES-1:0] nxt_dyn_brake;
  reg [`STM_AXES-1:0] nxt_decel;
  reg nxt_timing_alarm;
  reg [7:0] nxt_alarm_code;

  // Each channel filtered on its own so one path failing cannot mask the other
  stm_in_filter #(.FILT_CYCLES(FILT_CYCLES)) u_ch_a (
    .clk(CLK_SYS),
    .rst(RST),
    .pin_closed(SAFE_IN_A_CLOSED),
    .cut_ff(cut_a)
  );
  stm_in_filter #(.FILT_CYCLES(FILT_CYCLES)) u_ch_b (
    .clk(CLK_SYS),
    .rst(RST),
    .pin_closed(SAFE_IN_B_CLOSED),
    .cut_ff(cut_b)
  );

  // Channel combinations shared by every axis
  assign cut_any = cut_a | cut_b;
  assign cut_both = cut_a & cut_b;
  // Delayed copy resets to cut, so no false edge follows reset
  assign cut_rise = cut_any & ~cut_any_d_ff;
  // OR only after both stages, so skew between axis flags cannot glitch it
  assign speed_any = |speed_s2_ff;

  // Per-axis speed flags come from another domain; one synchroniser per bit
  always @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      speed_s1_ff <= {`STM_AXES{1'b0}};
      speed_s2_ff <= {`STM_AXES{1'b0}};
    end
    else
    begin
      speed_s1_ff <= AXIS_SPEED_NZ;
      speed_s2_ff <= speed_s1_ff;
    end
  end

  // Alarm clear request, synchronised
  always @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      clr_s1_ff <= 1'b0;
      clr_s2_ff <= 1'b0;
    end
    else
    begin
      clr_s1_ff <= ALARM_CLEAR;
      clr_s2_ff <= clr_s1_ff;
    end
  end

  // Forced stop input, synchronised; low means forced stop requested
  always @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      em_s1_ff <= 1'b0;
      em_s2_ff <= 1'b0;
    end
    else
    begin
      em_s1_ff <= FORCED_STOP_DECEL_IN_N;
      em_s2_ff <= em_s1_ff;
    end
  end

  // Sticky alarm; a running cut in the same cycle as a clear wins
  always @*
  begin
    nxt_alarm = alarm_ff;
    if (cut_rise & speed_any)
      nxt_alarm = 1'b1;
    else if (clr_s2_ff & ~cut_any)
      nxt_alarm = 1'b0;
  end

  // Clear is only honoured with both channels released, so it cannot hide a live cut
  always @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      cut_any_d_ff <= 1'b1;
      alarm_ff <= 1'b0;
    end
    else
    begin
      cut_any_d_ff <= cut_any;
      alarm_ff <= nxt_alarm;
    end
  end

  // Next output values; every axis takes the same cut so shut-off is simultaneous
  always @*
  begin
    nxt_mon_a = cut_a;
    nxt_mon_b = cut_b;
    nxt_mon_ab = cut_both;
    nxt_base_drive = {`STM_AXES{~cut_any}};
    nxt_dyn_brake = {`STM_AXES{cut_any}};
    // Torque-mode axes never get deceleration; others only before the cut
    nxt_decel = ~AXIS_TORQUE_MODE & {`STM_AXES{~em_s2_ff & ~cut_any}};
    nxt_timing_alarm = alarm_ff;
    nxt_alarm_code = `STM_ALARM_NONE;
    if (alarm_ff)
      nxt_alarm_code = `STM_ALARM_NUM;
  end

  // Monitor outputs; reset shows every channel shut off, the safe state
  always @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      SHUTOFF_MON_A_ON <= 1'b1;
      SHUTOFF_MON_B_ON <= 1'b1;
      SHUTOFF_MON_AB_ON <= 1'b1;
    end
    else
    begin
      SHUTOFF_MON_A_ON <= nxt_mon_a;
      SHUTOFF_MON_B_ON <= nxt_mon_b;
      SHUTOFF_MON_AB_ON <= nxt_mon_ab;
    end
  end

  // Power-stage controls; brake applied and drive off until both channels release
  always @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      BASE_DRIVE_EN <= {`STM_AXES{1'b0}};
      DYN_BRAKE_ON <= {`STM_AXES{1'b1}};
      DECEL_ALLOWED <= {`STM_AXES{1'b0}};
    end
    else
    begin
      BASE_DRIVE_EN <= nxt_base_drive;
      DYN_BRAKE_ON <= nxt_dyn_brake;
      DECEL_ALLOWED <= nxt_decel;
    end
  end

  // Alarm outputs lag the alarm register by one cycle
  always @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      SHUTOFF_TIMING_ALARM <= 1'b0;
      ALARM_CODE <= `STM_ALARM_NONE;
    end
    else
    begin
      SHUTOFF_TIMING_ALARM <= nxt_timing_alarm;
      ALARM_CODE <= nxt_alarm_code;
    end
  end
endmodule
`default_nettype wire

//--- core/stm_defs.vh
`ifndef STM_DEFS_VH
`define STM_DEFS_VH
// Clock period in ns
`define STM_CLK_PERIOD_NS 8
// Longest permitted test pulse, in us
`define STM_TEST_PULSE_US 1000
// Filter length: test pulse plus a 16-cycle margin, 125000 + 16 cycles at 8 ns
// Held as a sized literal so it meets the 18-bit counter without truncation
`define STM_FILT_CYCLES 18'h1e858
`define STM_CNT_W 18
`define STM_AXES 3
`define STM_SPEED_W 16
`define STM_ALARM_NUM 8'h3f
// Alarm code shown while no alarm stands
`define STM_ALARM_NONE 8'h00
`endif

//--- core/stm_in_filter.v
`timescale 1ns/1ns
`default_nettype none
`include "stm_defs.vh"
// One safety channel: synchroniser then off-pulse filter
module stm_in_filter #(
  parameter [`STM_CNT_W-1:0] FILT_CYCLES = `STM_FILT_CYCLES
) (
  input wire clk,
  input wire rst,
  input wire pin_closed,
  output reg cut_ff
);
  reg sync1_ff;
  reg sync2_ff;
  reg [`STM_CNT_W-1:0] cnt_ff;
  reg [`STM_CNT_W-1:0] nxt_cnt;
  reg nxt_cut;

  // Two-flop synchroniser; first stage read only by the second
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end
    else
    begin
      sync1_ff <= pin_closed;
      sync2_ff <= sync1_ff;
    end
  end

  // Open must persist past a test pulse before cut; closing releases at once
  always @*
  begin
    nxt_cnt = cnt_ff;
    nxt_cut = cut_ff;
    if (sync2_ff)
    begin
      nxt_cnt = {`STM_CNT_W{1'b0}};
      nxt_cut = 1'b0;
    end
    else if (cnt_ff >= FILT_CYCLES)
      nxt_cut = 1'b1;
    else
      nxt_cnt = cnt_ff + {{(`STM_CNT_W-1){1'b0}}, 1'b1};
  end

  // Reset starts in shut-off, the safe state
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_ff <= {`STM_CNT_W{1'b0}};
      cut_ff <= 1'b1;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      cut_ff <= nxt_cut;
    end
  end
endmodule
`default_nettype wire

//--- sim/stm_relay.sv
`timescale 1ns/1ns
`default_nettype none
// Safety relay at the far side of the safety inputs
module stm_relay (
  input wire logic clk,
  input wire logic [2:0] speed_nz,
  output logic a_closed,
  output logic b_closed,
  output logic stop_n
);
  initial
  begin
    a_closed = 1'b1;
    b_closed = 1'b1;
    stop_n = 1'b1;
  end
  // Both contacts move on one edge; a lone channel only when a test asks
  task automatic drive(input logic a, input logic b);
    @(negedge clk);
    a_closed = a;
    b_closed = b;
    // Forced stop lifts once both contacts close; a test pulse leaves it alone
    stop_n = stop_n | (a & b);
  endtask
  // Diagnostic pulse kept shorter than the input filter
  task automatic pulse(input int n);
    drive(1'b0, 1'b0);
    repeat (n) @(negedge clk);
    drive(1'b1, 1'b1);
  endtask
  // Forced stop first; rest=0 opens the contacts one cycle later without waiting for standstill, on purpose
  task automatic cut(input logic rest);
    @(negedge clk);
    stop_n = 1'b0;
    while (rest && speed_nz != 3'h0) @(negedge clk);
    drive(1'b0, 1'b0);
  endtask
endmodule
`default_nettype wire

//--- sim/stm_top_chk.sv
`timescale 1ns/1ns
`default_nettype none
`include "stm_defs.vh"
module stm_chk #(
  parameter [`STM_CNT_W-1:0] FILT_CYCLES = `STM_FILT_CYCLES
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic SAFE_IN_A_CLOSED,
  input wire logic SAFE_IN_B_CLOSED,
  input wire logic [`STM_AXES-1:0] AXIS_TORQUE_MODE,
  input wire logic SHUTOFF_MON_A_ON,
  input wire logic SHUTOFF_MON_B_ON,
  input wire logic SHUTOFF_MON_AB_ON,
  input wire logic [`STM_AXES-1:0] BASE_DRIVE_EN,
  input wire logic [`STM_AXES-1:0] DYN_BRAKE_ON,
  input wire logic [`STM_AXES-1:0] DECEL_ALLOWED,
  input wire logic SHUTOFF_TIMING_ALARM,
  input wire logic [7:0] ALARM_CODE
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  AST_AB_PATH: assert property (SHUTOFF_MON_AB_ON == (SHUTOFF_MON_A_ON && SHUTOFF_MON_B_ON))
    else $error("pair monitor wrong");
  AST_DRIVE: assert property (BASE_DRIVE_EN == {`STM_AXES{!(SHUTOFF_MON_A_ON || SHUTOFF_MON_B_ON)}})
    else $error("base drive wrong");
  AST_BRAKE: assert property (DYN_BRAKE_ON == ~BASE_DRIVE_EN)
    else $error("brake wrong");
  AST_CODE: assert property (ALARM_CODE == (SHUTOFF_TIMING_ALARM ? `STM_ALARM_NUM : 8'h00))
    else $error("alarm code wrong");
  AST_TORQUE: assert property ((DECEL_ALLOWED & AXIS_TORQUE_MODE & $past(AXIS_TORQUE_MODE)) == 3'h0)
    else $error("decel in torque mode");
  AST_A_CUT: assert property ($rose(SHUTOFF_MON_A_ON) |-> !$past(SAFE_IN_A_CLOSED, FILT_CYCLES))
    else $error("early cut a");
  AST_A_REL: assert property ($fell(SHUTOFF_MON_A_ON) |-> $past(SAFE_IN_A_CLOSED, 3))
    else $error("bad release a");
  AST_B_CUT: assert property ($rose(SHUTOFF_MON_B_ON) |-> !$past(SAFE_IN_B_CLOSED, FILT_CYCLES))
    else $error("early cut b");
  AST_B_REL: assert property ($fell(SHUTOFF_MON_B_ON) |-> $past(SAFE_IN_B_CLOSED, 3))
    else $error("bad release b");
  // The alarm output rises one cycle after the monitors rise
  AST_ALARM: assert property ($rose(SHUTOFF_TIMING_ALARM) |->
    $past(SHUTOFF_MON_A_ON || SHUTOFF_MON_B_ON) && !$past(SHUTOFF_MON_A_ON || SHUTOFF_MON_B_ON, 2))
    else $error("alarm without fresh cut");
endmodule
bind stm_top stm_chk #(.FILT_CYCLES(FILT_CYCLES)) u_chk (.*);
`default_nettype wire

//--- sim/stm_top_test.sv
`timescale 1ns/1ns
`default_nettype none
module stm_top_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic clr = 1'b0;
  logic [2:0] spd = 3'h0;
  logic [2:0] tq = 3'h0;
  logic ma, mb, mab, alm;
  logic [2:0] drv, db, dec;
  logic [7:0] code;
  wire a_c, b_c, st_n;
  int mismatches = 0;
  int samples_checked = 0;
  int cyc = 0;
  always #4 clk = ~clk;
  stm_relay prt (.clk(clk), .speed_nz(spd), .a_closed(a_c), .b_closed(b_c), .stop_n(st_n));
  stm_top #(.FILT_CYCLES(18'h14)) dut (.CLK_SYS(clk), .RST(rst), .SAFE_IN_A_CLOSED(a_c), .SAFE_IN_B_CLOSED(b_c),
    .AXIS_SPEED_NZ(spd), .AXIS_TORQUE_MODE(tq), .FORCED_STOP_DECEL_IN_N(st_n), .ALARM_CLEAR(clr),
    .SHUTOFF_MON_A_ON(ma), .SHUTOFF_MON_B_ON(mb), .SHUTOFF_MON_AB_ON(mab), .BASE_DRIVE_EN(drv),
    .DYN_BRAKE_ON(db), .DECEL_ALLOWED(dec), .SHUTOFF_TIMING_ALARM(alm), .ALARM_CODE(code));
  // Expected outputs follow from which channels are cut and the alarm
  task automatic chk(input logic a, input logic b, input logic al);
    samples_checked++;
    if ({ma, mb, mab, drv, db, alm, code} !== {a, b, a & b, {3{~(a | b)}}, {3{a | b}}, al, al ? 8'h3f : 8'h00})
    begin
      mismatches++;
      $display("CHECK FAILED %0t outputs %b %b %b %b %b %b %h", $time, ma, mb, mab, drv, db, alm, code);
    end
  endtask
  // Deceleration offer per axis
  task automatic chk_dec(input logic [2:0] e);
    samples_checked++;
    if (dec !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %0t decel %b", $time, dec);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Lone channel opening on purpose, against the both-together order
  task automatic t_single;
    prt.drive(1'b0, 1'b1);
    wt(40);
    chk(1'b1, 1'b0, 1'b0);
    prt.drive(1'b1, 1'b0);
    wt(40);
    chk(1'b0, 1'b1, 1'b0);
    prt.drive(1'b1, 1'b1);
    wt(10);
    chk(1'b0, 1'b0, 1'b0);
    $display("single channel done");
  endtask
  task automatic t_pulse;
    prt.pulse(12);
    wt(40);
    chk(1'b0, 1'b0, 1'b0);
    $display("test pulse done");
  endtask
  // Forced stop before the cut: deceleration offered only to the speed-mode axis
  task automatic t_stop;
    tq = 3'h5;
    prt.cut(1'b1);
    wt(4);
    chk_dec(3'h2);
    chk(1'b0, 1'b0, 1'b0);
    wt(36);
    chk(1'b1, 1'b1, 1'b0);
    chk_dec(3'h0);
    prt.drive(1'b1, 1'b1);
    tq = 3'h0;
    wt(10);
    $display("orderly stop done");
  endtask
  task automatic t_run;
    spd = 3'h2;
    prt.cut(1'b0);
    wt(40);
    chk(1'b1, 1'b1, 1'b1);
    prt.drive(1'b1, 1'b1);
    spd = 3'h0;
    wt(10);
    chk(1'b0, 1'b0, 1'b1);
    clr = 1'b1;
    wt(6);
    clr = 1'b0;
    wt(4);
    chk(1'b0, 1'b0, 1'b0);
    $display("running cut done");
  endtask
  initial
  begin
    wt(16);
    chk(1'b1, 1'b1, 1'b0);
    chk_dec(3'h0);
    rst = 1'b0;
    wt(6);
    chk(1'b0, 1'b0, 1'b0);
    t_pulse();
    t_single();
    t_stop();
    t_run();
    wrap_up();
  end
  // A hang shows up as a cycle count past the planned run length
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      mismatches++;
      wrap_up();
    end
  end
endmodule
`default_nettype wire
